// ### mdio_device.sv
`timescale 1ns/100ps
// Functional notes
// - controller keeps MDC at 5 MHz or less
// - eight 16-bit registers: 0-5, 29, 31
// - frame starts 32 ones then 01
// - opcode 10 read, 01 write, two 5-bit addresses
// - read turnaround Z0, then 16 bits MSB first
// - write turnaround 10, data, then release
// - opcode 00, station bit4 one: config read
// - opcode 00, station bit4 zero: config write
// - station bit3 ignored on config access
// - config address is station[2:0] over register field
// - config bytes 0-141 plus indirect management access
// - config read returns zero upper byte
// - config write keeps only low byte
// - config frames use same framing as standard
module mdio_device
   import mdio_pkg::*;
#(
   parameter logic [4:0] STATION_ADDR = 5'h00   // standard frame station match
) (
   // clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        RST_IN,
   // management link
   mdio_if.dev              link,
   // notice of each completed write
   output logic             WR_STROBE_OUT,
   output logic             WR_EXT_OUT,
   output logic [7:0]       WR_ADDR_OUT,
   output logic [15:0]      WR_DATA_OUT
);
   typedef enum logic [2:0] {
      ST_PRE  = 3'h0,
      ST_HDR  = 3'h1,
      ST_TA   = 3'h2,
      ST_DATA = 3'h3
   } state_type;

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling
   logic [1:0] pin_q, pin_rise;  // synced {mdio, mdc} and their rising edges
   logic       bit_in;      // synced data level
   logic       mdc_rise;    // one pulse per MDC rising edge

   pin_sync #(.W(2)) pin_sync_i (
      .CLOCK_IN (CLOCK_IN),
      .RST_IN   (RST_IN),
      .D_IN     ({link.mdio, link.mdc}),
      .Q_OUT    (pin_q),
      .RISE_OUT (pin_rise)
   );
   assign bit_in = pin_q[1];
   assign mdc_rise = pin_rise[0];

   ////////////////////////////////////////////////////////////////////////////
   // storage
   logic [15:0] mgmt_mem [0:7];                  // management registers
   logic [7:0]  cfg_mem [0:CFG_LAST_ADDR];       // configuration bytes

   // map a register field onto a management slot: {valid, index}
   function automatic logic [3:0] mgmt_slot(input logic [4:0] r);
      if (r <= MGMT_STD_LAST) begin
         return {1'b1, r[2:0]};
      end else if (r == MGMT_VENDOR_A) begin
         return 4'hE;
      end else if (r == MGMT_VENDOR_B) begin
         return 4'hF;
      end
      return 4'h0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // frame state
   state_type   state_ff, nxt_state;
   logic [5:0]  cnt_ff, nxt_cnt;         // preamble ones or bit position
   logic [11:0] hdr_ff, nxt_hdr;         // header bits so far
   kind_type    kind_ff, nxt_kind;       // decoded access
   logic [7:0]  addr_ff, nxt_addr;       // config address or register field
   logic [15:0] rsh_ff, nxt_rsh, wsh_ff, nxt_wsh;  // read data to send, write data taken
   logic        oe_ff, nxt_oe, out_ff, nxt_out;    // data line drive
   logic        stb_ff, nxt_stb, ext_ff, nxt_ext;  // write notice
   logic [7:0]  waddr_ff, nxt_waddr;
   logic [15:0] wdata_ff, nxt_wdata;
   // memory write requests
   logic        mgmt_we, cfg_we;
   logic [2:0]  mgmt_wi;
   logic [15:0] mgmt_wd;
   logic [7:0]  cfg_wa, cfg_wd;
   // header fields of the bit that completes it
   logic [12:0] hdr;
   logic [1:0]  op;
   logic [4:0]  sta, rsel;
   logic [7:0]  eaddr;
   logic [3:0]  slot;
   logic [15:0] word;

   assign hdr = {hdr_ff, bit_in};
   assign op = hdr[11:10];
   assign sta = hdr[9:5];
   assign rsel = hdr[4:0];
   assign eaddr = {sta[2:0], rsel};
   assign word = {wsh_ff[14:0], bit_in};

   // next-state logic; everything but the one-cycle write strobe moves only on a sampled MDC rise
   always_comb begin
      nxt_state = state_ff;
      nxt_kind = kind_ff;
      {nxt_cnt, nxt_hdr, nxt_addr, nxt_rsh, nxt_wsh} = {cnt_ff, hdr_ff, addr_ff, rsh_ff, wsh_ff};
      {nxt_oe, nxt_out, nxt_ext, nxt_waddr, nxt_wdata} =
         {oe_ff, out_ff, ext_ff, waddr_ff, wdata_ff};
      nxt_stb = 1'b0;
      {mgmt_we, mgmt_wi, mgmt_wd, cfg_we, cfg_wa, cfg_wd} = '0;
      slot = 4'h0;
      if (mdc_rise) begin
         case (state_ff)
            ST_PRE: begin
               // count ones; a zero after enough of them is the start
               if (bit_in) begin
                  if (cnt_ff < 6'(PREAMBLE_LEN)) begin
                     nxt_cnt = cnt_ff + 6'h01;
                  end
               end else if (cnt_ff == 6'(PREAMBLE_LEN)) begin
                  nxt_state = ST_HDR;
                  nxt_cnt = 6'h00;
               end else begin
                  nxt_cnt = 6'h00;
               end
            end
            ST_HDR: begin
               nxt_hdr = hdr[11:0];
               nxt_cnt = cnt_ff + 6'h01;
               if (cnt_ff == 6'(HDR_LEN - 1)) begin
                  nxt_state = ST_TA;
                  nxt_cnt = 6'h00;
                  nxt_kind = KIND_NONE;
                  nxt_rsh = 16'h0000;
                  nxt_addr = {3'h0, rsel};
                  slot = mgmt_slot(rsel);
                  if (hdr[12] != SOF_PATTERN[0]) begin
                     // broken start pattern: hunt for a new preamble
                     nxt_state = ST_PRE;
                  end else if (op == OP_READ && sta == STATION_ADDR && slot[3]) begin
                     nxt_kind = KIND_STD_RD;
                     nxt_rsh = mgmt_mem[slot[2:0]];
                  end else if (op == OP_WRITE && sta == STATION_ADDR && slot[3]) begin
                     nxt_kind = KIND_STD_WR;
                  end else if (op == OP_EXT) begin
                     nxt_addr = eaddr;
                     if (sta[EXT_RD_BIT]) begin
                        nxt_kind = KIND_EXT_RD;
                     end else begin
                        nxt_kind = KIND_EXT_WR;
                     end
                     slot = mgmt_slot(eaddr[4:0]);
                     if (eaddr <= CFG_LAST_ADDR) begin
                        nxt_rsh = {8'h00, cfg_mem[eaddr]};
                     end else if (eaddr[7:6] == IND_WINDOW && slot[3]) begin
                        // indirect window: one byte of a management register
                        if (eaddr[IND_HIGH_BIT]) begin
                           nxt_rsh = {8'h00, mgmt_mem[slot[2:0]][15:8]};
                        end else begin
                           nxt_rsh = {8'h00, mgmt_mem[slot[2:0]][7:0]};
                        end
                     end
                  end
               end
            end
            ST_TA: begin
               // unaddressed frames are walked to the end: data is never a preamble
               nxt_cnt = cnt_ff + 6'h01;
               if (kind_ff == KIND_STD_RD || kind_ff == KIND_EXT_RD) begin
                  nxt_oe = 1'b1;
                  if (cnt_ff == 6'h00) begin
                     nxt_out = 1'b0;
                  end else begin
                     nxt_out = rsh_ff[15];
                     nxt_rsh = {rsh_ff[14:0], 1'b0};
                  end
               end
               if (cnt_ff == 6'h01) begin
                  nxt_state = ST_DATA;
                  nxt_cnt = 6'h00;
               end
            end
            default: begin
               // data bits, most significant first
               nxt_wsh = word;
               nxt_cnt = cnt_ff + 6'h01;
               nxt_out = rsh_ff[15];
               nxt_rsh = {rsh_ff[14:0], 1'b0};
               if (cnt_ff == 6'h0F) begin
                  nxt_state = ST_PRE;
                  nxt_cnt = 6'h00;
                  nxt_oe = 1'b0;
                  nxt_out = 1'b0;
                  slot = mgmt_slot(addr_ff[4:0]);
                  if (kind_ff == KIND_STD_WR) begin
                     mgmt_we = 1'b1;
                     mgmt_wi = slot[2:0];
                     mgmt_wd = word;
                  end else if (kind_ff == KIND_EXT_WR) begin
                     if (addr_ff <= CFG_LAST_ADDR) begin
                        cfg_we = 1'b1;
                        cfg_wa = addr_ff;
                        cfg_wd = word[7:0];
                     end else if (addr_ff[7:6] == IND_WINDOW && slot[3]) begin
                        mgmt_we = 1'b1;
                        mgmt_wi = slot[2:0];
                        mgmt_wd = mgmt_mem[slot[2:0]];
                        if (addr_ff[IND_HIGH_BIT]) begin
                           mgmt_wd[15:8] = word[7:0];
                        end else begin
                           mgmt_wd[7:0] = word[7:0];
                        end
                     end
                  end
                  if (mgmt_we || cfg_we) begin
                     nxt_stb = 1'b1;
                     nxt_ext = (kind_ff == KIND_EXT_WR);
                     nxt_waddr = addr_ff;
                     nxt_wdata = (kind_ff == KIND_EXT_WR) ? {8'h00, word[7:0]} : word;
                  end
               end
            end
         endcase
      end
   end

   // state registers; reset drops any half-seen frame and releases the line
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         state_ff <= ST_PRE;
         kind_ff <= KIND_NONE;
         {cnt_ff, hdr_ff, addr_ff, rsh_ff, wsh_ff} <= '0;
         {oe_ff, out_ff, stb_ff, ext_ff, waddr_ff, wdata_ff} <= '0;
      end else begin
         state_ff <= nxt_state;
         kind_ff <= nxt_kind;
         {cnt_ff, hdr_ff, addr_ff, rsh_ff, wsh_ff} <=
            {nxt_cnt, nxt_hdr, nxt_addr, nxt_rsh, nxt_wsh};
         {oe_ff, out_ff, stb_ff, ext_ff, waddr_ff, wdata_ff} <=
            {nxt_oe, nxt_out, nxt_stb, nxt_ext, nxt_waddr, nxt_wdata};
      end
   end

   // register arrays; cleared by reset so reads are defined
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < 8; i++) begin
            mgmt_mem[i] <= MGMT_RESET_VAL;
         end
         for (int j = 0; j <= int'(CFG_LAST_ADDR); j++) begin
            cfg_mem[j] <= CFG_RESET_VAL;
         end
      end else begin
         if (mgmt_we) begin
            mgmt_mem[mgmt_wi] <= mgmt_wd;
         end
         if (cfg_we) begin
            cfg_mem[cfg_wa] <= cfg_wd;
         end
      end
   end

   assign link.dev_oe = oe_ff;
   assign link.dev_out = out_ff;
   assign WR_STROBE_OUT = stb_ff;
   assign WR_EXT_OUT = ext_ff;
   assign WR_ADDR_OUT = waddr_ff;
   assign WR_DATA_OUT = wdata_ff;
endmodule

// ### mdio_pkg.sv
package mdio_pkg;
   // clock and link timing
   localparam int CLK_PERIOD_NS = 10;      // system clock period
   localparam int MDC_MIN_PERIOD_NS = 200; // fastest allowed management clock (5 MHz)
   // half period of the generated clock, rounded up so MDC never exceeds its limit
   localparam int MDC_HALF_CYCLES =
      (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // frame layout
   localparam int PREAMBLE_LEN = 32;       // ones before the start pattern
   localparam int HDR_LEN = 13;            // second start bit, opcode, station, register
   localparam int FRAME_LEN = 64;          // bits in a whole frame
   localparam int TA_FIRST_BIT = 46;       // index of first turnaround bit
   localparam int DATA_FIRST_BIT = 48;     // index of first data bit
   localparam logic [1:0] SOF_PATTERN = 2'h1;
   localparam logic [1:0] TA_WRITE = 2'h2;

   // opcodes
   localparam logic [1:0] OP_EXT = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;

   // station select field bits used by extended access
   localparam int EXT_RD_BIT = 4;

   // register spaces
   localparam logic [7:0] CFG_LAST_ADDR = 8'h8D;    // last configuration byte
   localparam logic [1:0] IND_WINDOW = 2'h3;        // addr[7:6] of indirect window
   localparam int IND_HIGH_BIT = 5;                 // selects high byte in the window
   localparam logic [4:0] MGMT_VENDOR_A = 5'h1D;
   localparam logic [4:0] MGMT_VENDOR_B = 5'h1F;
   localparam logic [4:0] MGMT_STD_LAST = 5'h05;
   localparam logic [15:0] MGMT_RESET_VAL = 16'h0000;
   localparam logic [7:0] CFG_RESET_VAL = 8'h00;

   // what a decoded frame does
   typedef enum logic [2:0] {
      KIND_NONE   = 3'h0,
      KIND_STD_RD = 3'h1,
      KIND_STD_WR = 3'h2,
      KIND_EXT_RD = 3'h3,
      KIND_EXT_WR = 3'h4
   } kind_type;
endpackage

// ### mdio_if.sv
`timescale 1ns/100ps
interface mdio_if;
   logic mdc;        // management clock, made by the controller
   logic host_out;   // controller data drive value
   logic host_oe;    // controller drives the data line
   logic dev_out;    // device data drive value
   logic dev_oe;     // device drives the data line
   logic mdio;       // resolved line level, pulled up when nobody drives

   assign mdio = dev_oe ? dev_out : (host_oe ? host_out : 1'b1);

   modport host (output mdc, output host_out, output host_oe, input mdio);
   modport dev (input mdc, input mdio, output dev_out, output dev_oe);
endinterface

// ### pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         CLOCK_IN,
   input  wire logic         RST_IN,
   // pin side
   input  wire logic [W-1:0] D_IN,
   // synchronised side
   output logic      [W-1:0] Q_OUT,
   output logic      [W-1:0] RISE_OUT
);
   logic [W-1:0] meta_ff;     // first stage, read only by the second
   logic [W-1:0] sync_ff;     // second stage
   logic [W-1:0] prev_ff;     // delayed copy for edge finding
   logic [W-1:0] rise_ff;     // one-cycle rising edge pulse
   logic [W-1:0] nxt_rise;

   // edge finding only looks at settled stages
   always_comb begin
      nxt_rise = sync_ff & ~prev_ff;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
         rise_ff <= '0;
      end else begin
         meta_ff <= D_IN;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         rise_ff <= nxt_rise;
      end
   end

   assign Q_OUT = sync_ff;
   assign RISE_OUT = rise_ff;
endmodule

// ### mdio_host.sv
`timescale 1ns/100ps
module mdio_host
   import mdio_pkg::*;
(
   // clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        RST_IN,
   // management link
   mdio_if.host             link,
   // request
   input  wire logic        REQ_IN,
   input  wire logic [1:0]  OP_IN,
   input  wire logic [4:0]  STATION_IN,
   input  wire logic [4:0]  REG_IN,
   input  wire logic [15:0] WDATA_IN,
   // answer
   output logic             BUSY_OUT,
   output logic             DONE_OUT,
   output logic [15:0]      RDATA_OUT
);
   ////////////////////////////////////////////////////////////////////////////
   // sample the returned data line
   logic din;

   pin_sync #(.W(1)) pin_sync_i (
      .CLOCK_IN (CLOCK_IN),
      .RST_IN   (RST_IN),
      .D_IN     (link.mdio),
      .Q_OUT    (din),
      .RISE_OUT ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // frame engine
   logic        busy_ff, nxt_busy;
   logic        done_ff, nxt_done;
   logic        rd_ff, nxt_rd;          // frame turns the line round
   logic [63:0] frm_ff, nxt_frm;        // bits still to send, MSB first
   logic [5:0]  idx_ff, nxt_idx;        // bit being sent
   logic [4:0]  div_ff, nxt_div;        // half period divider
   logic        mdc_ff, nxt_mdc;
   logic        oe_ff, nxt_oe;
   logic [15:0] rdat_ff, nxt_rdat;
   logic        tick;                   // one-cycle enable per MDC half period
   logic        is_rd;

   assign tick = (div_ff == 5'(MDC_HALF_CYCLES - 1));
   assign is_rd = (OP_IN == OP_READ) || (OP_IN == OP_EXT && STATION_IN[EXT_RD_BIT]);

   // data changes on the falling half, the device samples on the rise
   always_comb begin
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_rd = rd_ff;
      nxt_frm = frm_ff;
      nxt_idx = idx_ff;
      nxt_div = busy_ff ? (tick ? 5'h00 : div_ff + 5'h01) : 5'h00;
      nxt_mdc = mdc_ff;
      nxt_oe = oe_ff;
      nxt_rdat = rdat_ff;
      if (!busy_ff) begin
         if (REQ_IN) begin
            // preamble, start, opcode, addresses, turnaround, data
            nxt_busy = 1'b1;
            nxt_rd = is_rd;
            nxt_frm = {{PREAMBLE_LEN{1'b1}}, SOF_PATTERN, OP_IN, STATION_IN, REG_IN,
                       TA_WRITE, is_rd ? 16'h0000 : WDATA_IN};
            nxt_idx = 6'h00;
            nxt_oe = 1'b1;
            nxt_mdc = 1'b0;
         end
      end else if (tick) begin
         if (!mdc_ff) begin
            nxt_mdc = 1'b1;
            // line is stable here; the device changed it after the last rise
            if (rd_ff && idx_ff >= 6'(DATA_FIRST_BIT)) begin
               nxt_rdat = {rdat_ff[14:0], din};
            end
         end else begin
            nxt_mdc = 1'b0;
            if (idx_ff == 6'(FRAME_LEN - 1)) begin
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
               nxt_oe = 1'b0;
            end else begin
               nxt_idx = idx_ff + 6'h01;
               nxt_frm = {frm_ff[62:0], 1'b0};
               // a read releases the line from the first turnaround bit
               nxt_oe = !(rd_ff && idx_ff >= 6'(TA_FIRST_BIT - 1));
            end
         end
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         rd_ff <= 1'b0;
         frm_ff <= 64'h0;
         idx_ff <= 6'h00;
         div_ff <= 5'h00;
         mdc_ff <= 1'b0;
         oe_ff <= 1'b0;
         rdat_ff <= 16'h0000;
      end else begin
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         rd_ff <= nxt_rd;
         frm_ff <= nxt_frm;
         idx_ff <= nxt_idx;
         div_ff <= nxt_div;
         mdc_ff <= nxt_mdc;
         oe_ff <= nxt_oe;
         rdat_ff <= nxt_rdat;
      end
   end

   assign link.mdc = mdc_ff;
   assign link.host_oe = oe_ff;
   assign link.host_out = frm_ff[63];
   assign BUSY_OUT = busy_ff;
   assign DONE_OUT = done_ff;
   assign RDATA_OUT = rdat_ff;
endmodule

// ### mdio_properties.sv
`timescale 1ns/100ps
module mdio_properties (
   // clock and reset
   input  wire logic CLOCK_IN,
   input  wire logic RST_IN,
   // link signals
   input  wire logic mdc,
   input  wire logic host_out,
   input  wire logic host_oe,
   input  wire logic dev_out,
   input  wire logic dev_oe,
   input  wire logic mdio
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);
   ////////////////////////////////////////////////////////////////////////////////
   // how long each party has held the line; frame lengths show up here
   logic [11:0] host_run_ff;   // cycles with host driving
   logic [11:0] nxt_host_run;
   logic [11:0] dev_run_ff;    // cycles with device driving
   logic [11:0] nxt_dev_run;
   // next counts, cleared whenever the driver lets go
   always_comb begin
      nxt_host_run = host_oe ? host_run_ff + 12'h001 : 12'h000;
      nxt_dev_run  = dev_oe ? dev_run_ff + 12'h001 : 12'h000;
   end
   // register the counts
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         host_run_ff <= 12'h000;
         dev_run_ff  <= 12'h000;
      end else begin
         host_run_ff <= nxt_host_run;
         dev_run_ff  <= nxt_dev_run;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // two drivers at once would fight on the shared line
   no_contention_a: assert property (!(host_oe && dev_oe))
      else $error("both ends drive the data line");
   mdc_high_hold_a: assert property ($rose(mdc) |-> mdc [*8])
      else $error("management clock high phase too short");
   mdc_low_hold_a: assert property ($fell(mdc) |-> !mdc [*8])
      else $error("management clock low phase too short");
   preamble_ones_a: assert property ($rose(host_oe) |-> (host_out && !mdc) [*8])
      else $error("frame does not open with ones and a low clock");
   ta_drive_zero_a: assert property ($rose(dev_oe) |-> !dev_out [*8])
      else $error("device turnaround bit is not zero");
   dev_rise_only_a: assert property (($changed(dev_out) || $changed(dev_oe)) |-> mdc)
      else $error("device changed the line while the clock is low");
   host_fall_only_a: assert property (host_oe && $changed(host_out) |-> !mdc)
      else $error("host changed the line while the clock is high");
   // seventeen bit times of 20 cycles: turnaround zero plus 16 data bits
   dev_span_a: assert property ($fell(dev_oe) |-> dev_run_ff >= 335 && dev_run_ff <= 345)
      else $error("device drive span is not seventeen bits");
   // a read releases at bit 46, a write holds all 64 bits
   host_span_a: assert property ($fell(host_oe) |->
      (host_run_ff >= 915 && host_run_ff <= 925) ||
      (host_run_ff >= 1275 && host_run_ff <= 1285))
      else $error("host drive span is neither a read nor a write");
   idle_level_a: assert property (!host_oe && !dev_oe |-> mdio)
      else $error("released line is not at the pulled-up level");
endmodule

// ### mdio_mgmt_and_ext_reg_access_test.sv
`timescale 1ns/100ps
module mdio_mgmt_and_ext_reg_access_test import mdio_pkg::*;;
   // host user side stimulus
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        req = 1'b0;
   logic [1:0]  op  = 2'h0;
   logic [4:0]  st  = 5'h00;
   logic [4:0]  rg  = 5'h00;
   logic [15:0] wd  = 16'h0000;
   // observed outputs
   logic        busy, done, wr_stb, wr_ext;
   logic [15:0] rdata, wr_data;
   logic [7:0]  wr_addr;
   // bookkeeping
   int error_cnt  = 0;
   int n_compared = 0;
   int stb_cnt    = 0;   // write strobes seen
   int exp_stb    = 0;   // write strobes expected
   ////////////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   mdio_if mdio_if_i ();
   mdio_host mdio_host_i (.CLOCK_IN(clk), .RST_IN(rst), .link(mdio_if_i.host), .REQ_IN(req),
      .OP_IN(op), .STATION_IN(st), .REG_IN(rg), .WDATA_IN(wd), .BUSY_OUT(busy),
      .DONE_OUT(done), .RDATA_OUT(rdata));
   mdio_device mdio_device_i (.CLOCK_IN(clk), .RST_IN(rst), .link(mdio_if_i.dev),
      .WR_STROBE_OUT(wr_stb), .WR_EXT_OUT(wr_ext), .WR_ADDR_OUT(wr_addr),
      .WR_DATA_OUT(wr_data));
   mdio_properties mdio_properties_i (.CLOCK_IN(clk), .RST_IN(rst), .mdc(mdio_if_i.mdc),
      .host_out(mdio_if_i.host_out), .host_oe(mdio_if_i.host_oe),
      .dev_out(mdio_if_i.dev_out), .dev_oe(mdio_if_i.dev_oe), .mdio(mdio_if_i.mdio));
   // count strobes so a missing or doubled write shows up
   always @(posedge clk) if (wr_stb === 1'b1) stb_cnt <= stb_cnt + 1;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one whole frame; the next request may go out in the done cycle
   task automatic xfer(input logic [1:0] o, input logic [4:0] s, r, input logic [15:0] d);
      int i;
      req = 1'b1;
      op  = o;
      st  = s;
      rg  = r;
      wd  = d;
      @(posedge clk);
      #1 req = 1'b0;
      check({31'h0, busy}, 32'h1);
      for (i = 0; i < 1400 && done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 1400) begin
         error_cnt++;
         tally_and_finish();
      end
      check(i, FRAME_LEN * 2 * MDC_HALF_CYCLES);
      check({31'h0, busy}, 32'h0);
   endtask
   task automatic rd(input logic [4:0] s, r, input logic [15:0] exp, input logic ext);
      xfer(ext ? OP_EXT : OP_READ, s, r, 16'h0000);
      check({16'h0000, rdata}, {16'h0000, exp});
   endtask
   // a committed write: one strobe and the decoded target
   task automatic wr(input logic ext, input logic [4:0] s, r, input logic [15:0] d,
                     input logic [7:0] ea, input logic [15:0] ed);
      xfer(ext ? OP_EXT : OP_WRITE, s, r, d);
      exp_stb++;
      check(stb_cnt, exp_stb);
      check({7'h00, wr_ext, wr_addr, wr_data}, {7'h00, ext, ea, ed});
   endtask
   function automatic logic [4:0] maddr(input int k);
      return (k < 6) ? 5'(k) : ((k == 6) ? MGMT_VENDOR_A : MGMT_VENDOR_B);
   endfunction
   function automatic logic [15:0] val(input int k);
      return 16'h1357 * 16'(k + 1);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int k;
      logic [15:0] v2;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      // all eight management registers, written then read back to back
      for (k = 0; k < 8; k++) wr(1'b0, 5'h00, maddr(k), val(k), {3'h0, maddr(k)}, val(k));
      for (k = 0; k < 8; k++) rd(5'h00, maddr(k), val(k), 1'b0);
      // unmapped register and foreign station are walked past
      xfer(OP_WRITE, 5'h00, 5'h06, 16'hBEEF);
      check(stb_cnt, exp_stb);
      rd(5'h00, 5'h06, 16'hFFFF, 1'b0);
      rd(5'h01, 5'h00, 16'hFFFF, 1'b0);
      // config bytes at both ends of the space, ignored bit set both ways
      wr(1'b1, 5'h0C, 5'h0D, 16'hA55A, 8'h8D, 16'h005A);
      rd(5'h14, 5'h0D, 16'h005A, 1'b1);
      wr(1'b1, 5'h00, 5'h00, 16'hFF3C, 8'h00, 16'h003C);
      rd(5'h18, 5'h00, 16'h003C, 1'b1);
      rd(5'h1C, 5'h0D, 16'h005A, 1'b1);
      rd(5'h14, 5'h0E, 16'h0000, 1'b1);
      // indirect window: low byte of register 2 changes alone
      v2 = val(2);
      wr(1'b1, 5'h06, 5'h02, 16'h7711, 8'hC2, 16'h0011);
      rd(5'h16, 5'h02, 16'h0011, 1'b1);
      rd(5'h17, 5'h02, {8'h00, v2[15:8]}, 1'b1);
      rd(5'h00, 5'h02, {v2[15:8], 8'h11}, 1'b0);
      tally_and_finish();
   end
endmodule
